// *** design/gpio5_pkg.sv ***
// Constants and types for the bank 5 pin configuration block (pins 5.2-5.7)
// Assumes an APB slave on i_clk; pads are resolved outside this design.
//
// What this block does
// - Bit 0 high makes pin input
// - Bit 1 high inverts pin value
// - Bit 7 high selects open drain
// - Pin 5.2 selects gpio, uart rx, ir rx
// - Pin 5.3 selects gpio, uart tx, ir tx
// - Pin 5.4 bit 2 selects data set ready
// - Pin 5.5 bit 2 selects request to send
// - Pin 5.6 bit 2 selects clear to send
// - Pin 5.7 bit 2 selects terminal ready
`default_nettype none
package gpio5_pkg;
   localparam int NUM_PINS = 6;
   localparam int APB_AW = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_5_2 = 8'h41;
   localparam logic [7:0] IDX_PIN_5_3 = 8'h42;
   localparam logic [7:0] IDX_PIN_5_4 = 8'h43;
   localparam logic [7:0] IDX_PIN_5_5 = 8'h44;
   localparam logic [7:0] IDX_PIN_5_6 = 8'h45;
   localparam logic [7:0] IDX_PIN_5_7 = 8'h46;
   localparam logic [7:0] RST_PIN_5_2 = 8'h01;
   localparam logic [7:0] RST_PIN_5_3 = 8'h00;
   localparam logic [7:0] RST_PIN_OTHER = 8'h01;
   // Field positions
   localparam int BIT_DIR = 0;
   localparam int BIT_POL = 1;
   localparam int BIT_SEL_LO = 2;
   localparam int BIT_SEL_HI = 3;
   localparam int BIT_ODRAIN = 7;
   // Writable masks
   localparam logic [7:0] MASK_SEL2 = 8'h8F;
   localparam logic [7:0] MASK_SEL1 = 8'h87;
   localparam int RESET_SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      FN_GPIO = 2'b00,
      FN_UART = 2'b01,
      FN_IR = 2'b10,
      FN_RSVD = 2'b11
   } pin_fn_t;

   typedef struct packed {
      logic odrain;
      pin_fn_t fn;
      logic invert;
      logic input_dir;
   } pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pad_drive_t;
endpackage : gpio5_pkg
`default_nettype wire

// *** design/gpio5_pin.sv ***
// One configurable pin: polarity, direction, driver type.
// Assumes the alternate function is already resolved by the parent.
`default_nettype none
module gpio5_pin
   import gpio5_pkg::*;
(
   input wire logic i_clk,           // Clock
   input wire logic i_rst,           // Sync reset
   input wire pin_cfg_t i_cfg,       // Pin configuration
   input wire logic i_alt,           // Alternate function active
   input wire logic i_alt_out_en,    // Alternate drives pin
   input wire logic i_alt_out,       // Alternate output value
   input wire logic i_gpio_out,      // Gpio output value
   input wire logic i_pad_in,        // Pad level, asynchronous
   output logic o_in_value,          // Synced, polarity-applied input
   output pad_drive_t o_pad          // Pad drive
);
   logic [2:0] sync_reg;
   logic in_reg;
   logic drive_val;
   logic drive_en;

   // ------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync_reg <= 3'b000;
      end else begin
         sync_reg <= {sync_reg[1:0], i_pad_in};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         in_reg <= 1'b0;
      end else if (sync_reg[1] == sync_reg[2]) begin
         in_reg <= sync_reg[2] ^ i_cfg.invert;
      end
   end

   assign o_in_value = in_reg;

   // ------------------------------------------------------------
   // Output drive
   // ------------------------------------------------------------
   always_comb begin
      if (i_alt) begin
         drive_en = i_alt_out_en;
      end else begin
         drive_en = !i_cfg.input_dir;
      end
      drive_val = (i_alt ? i_alt_out : i_gpio_out) ^ i_cfg.invert;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pad <= '0;
      end else if (i_cfg.odrain) begin
         o_pad.out <= 1'b0;
         o_pad.oe <= drive_en && !drive_val;
      end else begin
         o_pad.out <= drive_val;
         o_pad.oe <= drive_en;
      end
   end
endmodule : gpio5_pin
`default_nettype wire

// *** design/gpio5_bank.sv ***
// Bank 5 pins 5.2-5.7: control registers on APB and pin muxing.
// Assumes pad resolution outside; resets are synchronous to i_clk.
//
// The APB interface to the registers was decided locally.
`default_nettype none
module gpio5_bank
   import gpio5_pkg::*;
(
   input wire logic i_clk,                   // Clock, 20 MHz
   input wire logic i_rst,                   // Standby power-on reset
   input wire logic i_main_por,              // Main power-on reset
   input wire logic i_host_bus_rst,          // Host bus reset
   input wire logic i_psel,                  // APB select
   input wire logic i_penable,               // APB enable
   input wire logic i_pwrite,                // APB write
   input wire logic [APB_AW-1:0] i_paddr,    // APB byte address
   input wire logic [31:0] i_pwdata,         // APB write data
   input wire logic [3:0] i_pstrb,           // APB byte strobes
   output logic [31:0] o_prdata,             // APB read data
   output logic o_pready,                    // APB ready
   output logic o_pslverr,                   // APB error
   input wire logic [5:0] i_pad_in,          // Pad levels, 5.2..5.7
   output logic [5:0] o_pad_out,             // Pad output values
   output logic [5:0] o_pad_oe,              // Pad output enables
   input wire logic [5:0] i_gpio_out,        // Gpio data out per pin
   output logic [5:0] o_gpio_in,             // Gpio data in per pin
   input wire logic i_uart_b_transmit_out,   // Uart tx source
   input wire logic i_infrared_transmit_out, // Ir tx source
   input wire logic i_uart_b_request_to_send_n, // Uart rts source
   input wire logic i_uart_b_terminal_ready_n,  // Uart dtr source
   output logic o_uart_b_receive_in,         // To uart rx
   output logic o_infrared_receive_in,       // To ir rx
   output logic o_uart_b_data_set_ready_n,   // To uart dsr
   output logic o_uart_b_clear_to_send_n     // To uart cts
);
   logic [7:0] ctl_reg [NUM_PINS];
   pin_cfg_t cfg [NUM_PINS];
   logic [NUM_PINS-1:0] alt;
   logic [NUM_PINS-1:0] alt_oe;
   logic [NUM_PINS-1:0] alt_out;
   logic [NUM_PINS-1:0] in_val;
   logic [NUM_PINS-1:0] hit;
   logic wr_en;
   logic acc;
   logic [7:0] rd_mux;

   // Index of a pin for a register index; NUM_PINS when unmapped
   function automatic logic [2:0] pin_of(input logic [7:0] idx);
      logic [7:0] d;
      d = idx - IDX_PIN_5_2;
      if (idx >= IDX_PIN_5_2 && idx <= IDX_PIN_5_7) begin
         return d[2:0];
      end
      return 3'(NUM_PINS);
   endfunction : pin_of

   function automatic logic [7:0] wmask(input int p);
      return (p < 2) ? MASK_SEL2 : MASK_SEL1;
   endfunction : wmask

   function automatic logic [7:0] rst_val(input int p);
      if (p == 0) begin
         return RST_PIN_5_2;
      end
      if (p == 1) begin
         return RST_PIN_5_3;
      end
      return RST_PIN_OTHER;
   endfunction : rst_val

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   logic [2:0] sel_pin;
   logic aligned;
   assign aligned = (i_paddr[1:0] == 2'b00) && (i_paddr[APB_AW-1:10] == '0);
   assign sel_pin = aligned ? pin_of(i_paddr[9:2]) : 3'(NUM_PINS);
   assign acc = i_psel && i_penable;
   assign wr_en = acc && i_pwrite && i_pstrb[0];
   assign o_pready = 1'b1;
   assign o_pslverr = acc && (sel_pin == 3'(NUM_PINS));

   always_comb begin
      rd_mux = 8'h00;
      for (int p = 0; p < NUM_PINS; p++) begin
         if (sel_pin == 3'(p)) begin
            rd_mux = ctl_reg[p];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= {24'h00_0000, rd_mux};
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_reg
         logic clr;
         if (g == 1) begin : g_extra
            assign clr = i_rst || i_main_por || i_host_bus_rst;
         end else begin : g_plain
            assign clr = i_rst;
         end
         assign hit[g] = (sel_pin == 3'(g));
         always_ff @(posedge i_clk) begin
            if (clr) begin
               ctl_reg[g] <= rst_val(g);
            end else if (wr_en && hit[g]) begin
               ctl_reg[g] <= i_pwdata[7:0] & wmask(g);
            end
         end
         always_comb begin
            cfg[g].input_dir = ctl_reg[g][BIT_DIR];
            cfg[g].invert = ctl_reg[g][BIT_POL];
            cfg[g].odrain = ctl_reg[g][BIT_ODRAIN];
            cfg[g].fn = pin_fn_t'(ctl_reg[g][BIT_SEL_HI:BIT_SEL_LO]);
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Alternate function muxing
   // ------------------------------------------------------------
   always_comb begin
      alt = '0;
      alt_oe = '0;
      alt_out = '0;
      // Pin 5.2: receive inputs
      unique case (cfg[0].fn)
         FN_UART: alt[0] = 1'b1;
         FN_IR: alt[0] = 1'b1;
         FN_GPIO, FN_RSVD: alt[0] = 1'b0;
      endcase
      // Pin 5.3: transmit outputs
      unique case (cfg[1].fn)
         FN_UART: begin
            alt[1] = 1'b1;
            alt_oe[1] = 1'b1;
            alt_out[1] = i_uart_b_transmit_out;
         end
         FN_IR: begin
            alt[1] = 1'b1;
            alt_oe[1] = 1'b1;
            alt_out[1] = i_infrared_transmit_out;
         end
         FN_GPIO, FN_RSVD: alt[1] = 1'b0;
      endcase
      alt[2] = ctl_reg[2][BIT_SEL_LO];
      alt[3] = ctl_reg[3][BIT_SEL_LO];
      alt_oe[3] = 1'b1;
      alt_out[3] = i_uart_b_request_to_send_n;
      alt[4] = ctl_reg[4][BIT_SEL_LO];
      alt[5] = ctl_reg[5][BIT_SEL_LO];
      alt_oe[5] = 1'b1;
      alt_out[5] = i_uart_b_terminal_ready_n;
   end

   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         pad_drive_t drv;
         gpio5_pin u_pin (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_cfg(cfg[g]),
            .i_alt(alt[g]),
            .i_alt_out_en(alt_oe[g]),
            .i_alt_out(alt_out[g]),
            .i_gpio_out(i_gpio_out[g]),
            .i_pad_in(i_pad_in[g]),
            .o_in_value(in_val[g]),
            .o_pad(drv)
         );
         assign o_pad_out[g] = drv.out;
         assign o_pad_oe[g] = drv.oe;
      end
   endgenerate

   // ------------------------------------------------------------
   // Inputs to peripherals; uart and ir inputs idle high, gpio inputs low, when not routed
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_gpio_in <= '0;
         o_uart_b_receive_in <= 1'b1;
         o_infrared_receive_in <= 1'b1;
         o_uart_b_data_set_ready_n <= 1'b1;
         o_uart_b_clear_to_send_n <= 1'b1;
      end else begin
         o_gpio_in <= in_val & ~alt;
         o_uart_b_receive_in <= (cfg[0].fn == FN_UART) ? in_val[0] : 1'b1;
         o_infrared_receive_in <= (cfg[0].fn == FN_IR) ? in_val[0] : 1'b1;
         o_uart_b_data_set_ready_n <= alt[2] ? in_val[2] : 1'b1;
         o_uart_b_clear_to_send_n <= alt[4] ? in_val[4] : 1'b1;
      end
   end
endmodule : gpio5_bank
`default_nettype wire

// *** dv/gpio5_bank_props.sv ***
// Checker for gpio5_bank, bound to the top module
// Assumes only the top module ports are visible
`default_nettype none
module gpio5_bank_props
   import gpio5_pkg::*;
(
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_main_por, // Main
   input wire logic i_host_bus_rst, // Bus
   input wire logic i_psel, // Sel
   input wire logic i_penable, // En
   input wire logic i_pwrite, // Wr
   input wire logic [APB_AW-1:0] i_paddr, // Addr
   input wire logic [31:0] i_pwdata, // Wdata
   input wire logic [3:0] i_pstrb, // Strb
   input wire logic [31:0] o_prdata, // Rdata
   input wire logic o_pslverr, // Err
   input wire logic [5:0] o_pad_out, // Pad
   input wire logic [5:0] o_pad_oe, // Oe
   input wire logic [5:0] o_gpio_in, // In
   input wire logic [5:0] i_gpio_out, // Out
   input wire logic i_uart_b_transmit_out, // Tx
   input wire logic i_infrared_transmit_out, // Ir
   input wire logic i_uart_b_request_to_send_n // Rts
);
   // ---
   // Shadow registers
   // ---
   logic [7:0] c [NUM_PINS];
   wire logic acc = i_psel && i_penable;
   wire logic [11:0] ix = (i_paddr >> 2) - 12'h041;
   wire logic hit = i_paddr[1:0] == 2'b00 && ix < 12'h006;
   wire logic wr = acc && i_pwrite && i_pstrb[0] && hit;
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < NUM_PINS; k++) begin
         if (i_rst || (k == 1 && (i_main_por || i_host_bus_rst))) begin
            c[k] <= k == 1 ? RST_PIN_5_3 : RST_PIN_OTHER;
         end else if (wr && ix == 12'(k)) begin
            c[k] <= i_pwdata[7:0] & (k < 2 ? MASK_SEL2 : MASK_SEL1);
         end
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_read;
      acc && !i_pwrite && hit;
   endsequence
   property p_slverr;
      acc |-> o_pslverr == !hit;
   endproperty
   a_slverr: assert property (p_slverr) else $error("bad slverr");
   property p_rdback;
      s_read |-> o_prdata == {24'h00_0000, c[ix[2:0]]};
   endproperty
   a_rdback: assert property (p_rdback) else $error("bad read");
   property p_rst;
      disable iff (1'b0) i_rst |=> o_pad_oe == 6'h00 && o_gpio_in == 6'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_dir;
      $past(!c[0][7] && c[0][3] == c[0][2])
         |-> o_pad_oe[0] == !$past(c[0][0]);
   endproperty
   a_dir: assert property (p_dir) else $error("bad dir");
   property p_pol;
      $past((c[0] & 8'h81) == 8'h00 && c[0][3] == c[0][2])
         |-> o_pad_out[0] == $past(i_gpio_out[0] ^ c[0][1]);
   endproperty
   a_pol: assert property (p_pol) else $error("bad polarity");
   property p_odrain;
      $past(c[0][7] && c[0][3] == c[0][2]) |-> !o_pad_out[0]
         && o_pad_oe[0] == $past(!c[0][0] && !(i_gpio_out[0] ^ c[0][1]));
   endproperty
   a_odrain: assert property (p_odrain) else $error("bad drain");
   property p_tx;
      $past((c[1][3] ^ c[1][2]) && !c[1][7]) |-> o_pad_oe[1]
         && o_pad_out[1] == $past(c[1][1] ^ (c[1][2] ?
         i_uart_b_transmit_out : i_infrared_transmit_out));
   endproperty
   a_tx: assert property (p_tx) else $error("bad tx");
   property p_rts;
      $past(c[3][2] && !c[3][7]) |-> o_pad_oe[3]
         && o_pad_out[3] == $past(c[3][1] ^ i_uart_b_request_to_send_n);
   endproperty
   a_rts: assert property (p_rts) else $error("bad rts");
endmodule : gpio5_bank_props
bind gpio5_bank gpio5_bank_props u_props (.i_clk, .i_rst, .i_main_por,
   .i_host_bus_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .i_pstrb, .o_prdata, .o_pslverr, .o_pad_out, .o_pad_oe, .o_gpio_in,
   .i_gpio_out, .i_uart_b_transmit_out, .i_infrared_transmit_out,
   .i_uart_b_request_to_send_n);
`default_nettype wire

// *** dv/test_gpio5_bank.sv ***
// Bench for gpio5_bank: registers over APB, pin routing
// Assumes the design and checker files are compiled first
`default_nettype none
module test_gpio5_bank;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio5_pkg::*;
   logic i_clk = 0, i_rst = 1, i_main_por = 0, i_host_bus_rst = 0;
   logic i_psel = 0, i_penable = 0, i_pwrite = 0, err;
   logic [APB_AW-1:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rd, seed = 32'h0000_6816;
   logic [3:0] i_pstrb = 4'hF;
   logic [5:0] i_pad_in = '0, i_gpio_out = '0;
   logic [5:0] o_pad_out, o_pad_oe, o_gpio_in;
   logic i_uart_b_transmit_out = 0, i_infrared_transmit_out = 0;
   logic i_uart_b_request_to_send_n = 0, i_uart_b_terminal_ready_n = 0;
   logic o_pready, o_pslverr, o_uart_b_receive_in, o_infrared_receive_in;
   logic o_uart_b_data_set_ready_n, o_uart_b_clear_to_send_n;
   logic [7:0] cfg [6];
   logic [7:0] corner [4] = '{8'h00, 8'h04, 8'h09, 8'h8E};
   int failures = 0, n_compared = 0;
   gpio5_bank dut (.i_clk, .i_rst, .i_main_por, .i_host_bus_rst, .i_psel,
      .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata,
      .o_pready, .o_pslverr, .i_pad_in, .o_pad_out, .o_pad_oe, .i_gpio_out,
      .o_gpio_in, .i_uart_b_transmit_out, .i_infrared_transmit_out,
      .i_uart_b_request_to_send_n, .i_uart_b_terminal_ready_n,
      .o_uart_b_receive_in, .o_infrared_receive_in,
      .o_uart_b_data_set_ready_n, .o_uart_b_clear_to_send_n);
   initial forever #25 i_clk = ~i_clk;
   // ---
   // Helpers
   // ---
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [11:0] ba(input int k);
      return {2'b00, IDX_PIN_5_2 + 8'(k), 2'b00};
   endfunction : ba
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_psel <= 1;
      i_penable <= 0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 16);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
      if (n == 16) begin
         failures++;
         give_verdict();
      end
   endtask : apb
   task automatic check_pins();
      logic [7:0] v;
      logic [1:0] fn;
      logic [3:0] rx;
      logic iv, s, de, ai, ao;
      rx = 4'hF;
      for (int k = 0; k < 6; k++) begin
         v = cfg[k];
         fn = k < 2 ? v[3:2] : {1'b0, v[2]};
         iv = i_pad_in[k] ^ v[1];
         ai = (fn == 2'b01 || fn == 2'b10) && k % 2 == 0;
         ao = (fn == 2'b01 || fn == 2'b10) && k % 2 == 1;
         chk(o_gpio_in[k], (ai || ao) ? 1'b0 : iv);
         if (k == 0) rx[1:0] = {fn == 2'b10 ? iv : 1'b1, fn == 2'b01 ? iv : 1'b1};
         if (ai && k > 0) rx[k / 2 + 1] = iv;
         s = k == 1 ? (fn == 2'b01 ? i_uart_b_transmit_out
            : i_infrared_transmit_out) : k == 3 ? i_uart_b_request_to_send_n
            : i_uart_b_terminal_ready_n;
         s = (ao ? s : i_gpio_out[k]) ^ v[1];
         // Alternate input pins never drive the pad
         de = !ai && (ao || !v[0]);
         chk(o_pad_oe[k], v[7] ? de && !s : de);
         if (de) chk(o_pad_out[k], v[7] ? 1'b0 : s);
      end
      chk({o_uart_b_clear_to_send_n, o_uart_b_data_set_ready_n,
           o_infrared_receive_in, o_uart_b_receive_in}, rx);
   endtask : check_pins
   // ---
   // Main sequence
   // ---
   initial begin
      logic [31:0] w;
      repeat (3) @(posedge i_clk);
      i_rst <= 0;
      for (int k = 0; k < 6; k++) begin
         apb(0, ba(k), 0);
         chk(rd, k == 1 ? RST_PIN_5_3 : k == 0 ? RST_PIN_5_2 : RST_PIN_OTHER);
         apb(1, ba(k), 32'hFFFF_FFFF);
         apb(0, ba(k), 0);
         chk(rd, k < 2 ? MASK_SEL2 : MASK_SEL1);
      end
      i_pstrb <= 4'hE;
      apb(1, ba(0), 0);
      i_pstrb <= 4'hF;
      apb(1, 12'h100, 32'h0000_00FF);
      chk(err, 1'b1);
      apb(0, 12'h106, 0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(0, ba(0), 0);
      chk(rd, MASK_SEL2);
      $display("test registers done");
      for (int r = 0; r < 2; r++) begin
         apb(1, ba(1), 32'h0000_0081);
         i_main_por <= r == 0;
         i_host_bus_rst <= r == 1;
         @(posedge i_clk);
         i_main_por <= 0;
         i_host_bus_rst <= 0;
         apb(0, ba(1), 0);
         chk(rd, RST_PIN_5_3);
         apb(0, ba(2), 0);
         chk(rd, MASK_SEL1);
      end
      $display("test other resets done");
      for (int t = 0; t < 40; t++) begin
         for (int k = 0; k < 6; k++) begin
            w = t < 4 ? {24'h00_0000, corner[t]} : rnd();
            apb(1, ba(k), w);
            cfg[k] = w[7:0] & (k < 2 ? MASK_SEL2 : MASK_SEL1);
         end
         {i_pad_in, i_gpio_out} <= 12'(rnd());
         {i_uart_b_transmit_out, i_infrared_transmit_out,
          i_uart_b_request_to_send_n, i_uart_b_terminal_ready_n} <= 4'(rnd());
         repeat (8) @(posedge i_clk);
         check_pins();
      end
      $display("test pin routing done");
      give_verdict();
   end
endmodule : test_gpio5_bank
`default_nettype wire
